// ### tof_pkg.sv
// Notes on behaviour
// [R1] Third-stop fine time reads at 14h, value in bits 22-0, parity bit 23.
// [R2] Fourth-stop fine time reads at 16h, value in bits 22-0, parity bit 23.
// [R3] Fifth-stop fine time reads at 18h, value in bits 22-0, parity bit 23.
// [R4] Third-stop coarse count reads at 15h, 16 bits in 15-0, parity bit 23.
// [R5] Fourth-stop coarse count reads at 17h, 16 bits in 15-0, parity 23.
// [R6] Fifth-stop coarse count reads at 19h, 16 bits in 15-0, parity bit 23.
// [R7] Count bits 22-16 carry averaging extension, zero when averaging is off.
// [R8] All six registers are read-only and reset to all zeros, parity included.
// [R9] Same addresses on each converter; reached only while its select is low.
// [R10] Parity covers the lower 23 bits; polarity is a parameter, even default.
package tof_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int FINE_W = 23;
  localparam int CNT_W = 16;
  localparam int EXT_W = 7;
  localparam int EXT_LSB = 16;
  localparam int PAR_BIT = 23;
  localparam int NUM_STOPS = 3;
  localparam int IDX_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_STOP3_FINE = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_STOP3_COARSE = 6'h15;
  localparam logic [ADDR_W-1:0] ADDR_STOP4_FINE = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_STOP4_COARSE = 6'h17;
  localparam logic [ADDR_W-1:0] ADDR_STOP5_FINE = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_STOP5_COARSE = 6'h19;
  localparam logic [DATA_W-1:0] RESULT_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 24'h000000;
  localparam logic [EXT_W-1:0] EXT_OFF = 7'h00;

  // Parity over the 23 value bits; odd_sel flips the polarity
  function automatic logic tof_parity(input logic [FINE_W-1:0] v,
                                      input logic odd_sel);
    tof_parity = (^v) ^ odd_sel;
  endfunction

  function automatic logic [DATA_W-1:0] tof_word(input logic [FINE_W-1:0] v,
                                                 input logic odd_sel);
    tof_word = {tof_parity(v, odd_sel), v};
  endfunction
endpackage : tof_pkg

// ### tof_stop_slot.sv
module tof_stop_slot #(
  parameter bit PARITY_ODD = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [tof_pkg::FINE_W-1:0] fine_i,
  input wire logic [tof_pkg::CNT_W-1:0] coarse_i,
  input wire logic [tof_pkg::EXT_W-1:0] ext_i,
  input wire logic avg_active_i,
  output logic [tof_pkg::DATA_W-1:0] fine_reg_o,
  output logic [tof_pkg::DATA_W-1:0] coarse_reg_o
);
  logic [tof_pkg::DATA_W-1:0] fine_r, fine_nxt;
  logic [tof_pkg::DATA_W-1:0] coarse_r, coarse_nxt;
  logic [tof_pkg::EXT_W-1:0] ext_eff;

  always_comb begin
    fine_nxt = fine_r;
    coarse_nxt = coarse_r;
    // Extension only meaningful while averaging accumulates
    ext_eff = avg_active_i ? ext_i : tof_pkg::EXT_OFF; // [R7]
    if (wr_i) begin
      fine_nxt = tof_pkg::tof_word(fine_i, PARITY_ODD); // [R10]
      coarse_nxt = tof_pkg::tof_word({ext_eff, coarse_i}, PARITY_ODD); // [R7]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fine_r <= tof_pkg::RESULT_RESET; // [R8]
      coarse_r <= tof_pkg::RESULT_RESET; // [R8]
    end else begin
      fine_r <= fine_nxt;
      coarse_r <= coarse_nxt;
    end
  end

  assign fine_reg_o = fine_r;
  assign coarse_reg_o = coarse_r;
endmodule // tof_stop_slot

// ### tof_result_regs.sv
module tof_result_regs #(
  parameter bit PARITY_ODD = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic converter_select_n_i,
  input wire logic rd_i,
  input wire logic [tof_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [tof_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic res_wr_i,
  input wire logic [tof_pkg::IDX_W-1:0] res_idx_i,
  input wire logic [tof_pkg::FINE_W-1:0] res_fine_i,
  input wire logic [tof_pkg::CNT_W-1:0] res_coarse_i,
  input wire logic [tof_pkg::EXT_W-1:0] res_ext_i,
  input wire logic avg_active_i
);
  logic [tof_pkg::DATA_W-1:0] fine_w [tof_pkg::NUM_STOPS];
  logic [tof_pkg::DATA_W-1:0] coarse_w [tof_pkg::NUM_STOPS];
  logic [tof_pkg::NUM_STOPS-1:0] slot_wr;

  // Select pin synchroniser: three stages, change taken once 2 and 3 agree
  logic sel_s1_r, sel_s2_r, sel_s3_r, sel_act_r;
  logic sel_s1_nxt, sel_s2_nxt, sel_s3_nxt, sel_act_nxt;

  always_comb begin
    sel_s1_nxt = converter_select_n_i;
    sel_s2_nxt = sel_s1_r;
    sel_s3_nxt = sel_s2_r;
    sel_act_nxt = sel_act_r;
    if (sel_s2_r == sel_s3_r) begin
      sel_act_nxt = !sel_s3_r; // [R9]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_s3_r <= 1'b1;
      sel_act_r <= 1'b0;
    end else begin
      sel_s1_r <= sel_s1_nxt;
      sel_s2_r <= sel_s2_nxt;
      sel_s3_r <= sel_s3_nxt;
      sel_act_r <= sel_act_nxt;
    end
  end

  // One slot per stop; the engine write port is not gated by the select
  for (genvar g = 0; g < tof_pkg::NUM_STOPS; g++) begin : g_slot
    assign slot_wr[g] = res_wr_i &&
                        (res_idx_i == tof_pkg::IDX_W'(g));
    tof_stop_slot #(
      .PARITY_ODD(PARITY_ODD)
    ) u_slot (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .wr_i(slot_wr[g]),
      .fine_i(res_fine_i),
      .coarse_i(res_coarse_i),
      .ext_i(res_ext_i),
      .avg_active_i(avg_active_i),
      .fine_reg_o(fine_w[g]),
      .coarse_reg_o(coarse_w[g])
    );
  end

  // Read path
  logic [tof_pkg::DATA_W-1:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic [tof_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    unique case (rd_addr_i)
      tof_pkg::ADDR_STOP3_FINE: rd_mux = fine_w[0]; // [R1]
      tof_pkg::ADDR_STOP3_COARSE: rd_mux = coarse_w[0]; // [R4]
      tof_pkg::ADDR_STOP4_FINE: rd_mux = fine_w[1]; // [R2]
      tof_pkg::ADDR_STOP4_COARSE: rd_mux = coarse_w[1]; // [R5]
      tof_pkg::ADDR_STOP5_FINE: rd_mux = fine_w[2]; // [R3]
      tof_pkg::ADDR_STOP5_COARSE: rd_mux = coarse_w[2]; // [R6]
      default: rd_mux = tof_pkg::UNMAPPED_DATA;
    endcase
  end

  always_comb begin
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    // Reads while deselected are dropped; data keeps its last value
    if (rd_i && sel_act_r) begin // [R9]
      rd_data_nxt = rd_mux;
      rd_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_r <= tof_pkg::RESULT_RESET;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;

  // Checks
  property p_stop3_fine;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_act_r && rd_addr_i == tof_pkg::ADDR_STOP3_FINE)
      |=> rd_valid_o && rd_data_o == $past(fine_w[0]);
  endproperty
  a_stop3_fine: assert property (p_stop3_fine) // [R1]
    else $error("stop3 fine read mismatch");

  property p_stop4_fine;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_act_r && rd_addr_i == tof_pkg::ADDR_STOP4_FINE)
      |=> rd_data_o[tof_pkg::FINE_W-1:0] ==
          $past(fine_w[1][tof_pkg::FINE_W-1:0]);
  endproperty
  a_stop4_fine: assert property (p_stop4_fine) // [R2]
    else $error("stop4 fine read mismatch");

  property p_stop5_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    (res_wr_i && res_idx_i == 2'h2)
      |=> fine_w[2][tof_pkg::FINE_W-1:0] == $past(res_fine_i);
  endproperty
  a_stop5_write: assert property (p_stop5_write) // [R3]
    else $error("stop5 fine result not stored");

  property p_stop3_coarse;
    @(posedge clk_i) disable iff (!rst_n_i)
    (res_wr_i && res_idx_i == 2'h0)
      |=> coarse_w[0][tof_pkg::CNT_W-1:0] == $past(res_coarse_i);
  endproperty
  a_stop3_coarse: assert property (p_stop3_coarse) // [R4]
    else $error("stop3 coarse count not stored");

  property p_stop4_coarse;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_act_r && rd_addr_i == tof_pkg::ADDR_STOP4_COARSE)
      |=> rd_data_o == $past(coarse_w[1]);
  endproperty
  a_stop4_coarse: assert property (p_stop4_coarse) // [R5]
    else $error("stop4 coarse read mismatch");

  property p_stop5_coarse;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_act_r && rd_addr_i == tof_pkg::ADDR_STOP5_COARSE)
      |=> rd_data_o == $past(coarse_w[2]);
  endproperty
  a_stop5_coarse: assert property (p_stop5_coarse) // [R6]
    else $error("stop5 coarse read mismatch");

  // Index 3 writes nothing, so it is kept out of the slot lookup
  property p_ext_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    (res_wr_i && !avg_active_i && res_idx_i < tof_pkg::NUM_STOPS)
      |=> coarse_w[$past(res_idx_i)][tof_pkg::PAR_BIT-1:tof_pkg::EXT_LSB] ==
          tof_pkg::EXT_OFF;
  endproperty
  a_ext_off: assert property (p_ext_off) // [R7]
    else $error("extension not zero outside averaging");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    !res_wr_i ##1 !res_wr_i |-> $stable(fine_w[1]) && $stable(coarse_w[1]);
  endproperty
  a_hold: assert property (p_hold) // [R8]
    else $error("result changed without a write");

  property p_desel;
    @(posedge clk_i) disable iff (!rst_n_i)
    !sel_act_r |=> !rd_valid_o;
  endproperty
  a_desel: assert property (p_desel) // [R9]
    else $error("read answered while deselected");

  property p_parity;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_valid_o && rd_data_o != tof_pkg::RESULT_RESET |->
      rd_data_o[tof_pkg::PAR_BIT] ==
      tof_pkg::tof_parity(rd_data_o[tof_pkg::FINE_W-1:0], PARITY_ODD);
  endproperty
  a_parity: assert property (p_parity) // [R10]
    else $error("parity bit wrong");

  property p_ext_on;
    @(posedge clk_i) disable iff (!rst_n_i)
    (res_wr_i && avg_active_i && res_idx_i == tof_pkg::IDX_W'(1))
      |=> coarse_w[1][tof_pkg::PAR_BIT-1:tof_pkg::EXT_LSB] ==
          $past(res_ext_i);
  endproperty
  a_ext_on: assert property (p_ext_on) // [R7]
    else $error("extension not kept during averaging");

  property p_stop5_fine_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_act_r && rd_addr_i == tof_pkg::ADDR_STOP5_FINE)
      |=> rd_valid_o && rd_data_o == $past(fine_w[2]);
  endproperty
  a_stop5_fine_rd: assert property (p_stop5_fine_rd) // [R3]
    else $error("stop5 fine read mismatch");

  property p_stop3_coarse_rd;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_act_r && rd_addr_i == tof_pkg::ADDR_STOP3_COARSE)
      |=> rd_valid_o && rd_data_o == $past(coarse_w[0]);
  endproperty
  a_stop3_coarse_rd: assert property (p_stop3_coarse_rd) // [R4]
    else $error("stop3 coarse read mismatch");

  // Reset itself is the antecedent, so no disable clause here
  property p_rst_zero;
    @(posedge clk_i)
    !rst_n_i |=> !rd_valid_o && rd_data_o == tof_pkg::RESULT_RESET &&
      fine_w[0] == tof_pkg::RESULT_RESET &&
      coarse_w[2] == tof_pkg::RESULT_RESET;
  endproperty
  a_rst_zero: assert property (p_rst_zero) // [R8]
    else $error("result not cleared by reset");

  property p_desel_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    !sel_act_r |=> $stable(rd_data_o);
  endproperty
  a_desel_hold: assert property (p_desel_hold) // [R9]
    else $error("read data moved while deselected");

  // Select may only open after the pin stood low through the sync stages
  property p_sel_rise;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(sel_act_r) |-> !$past(converter_select_n_i, 3) &&
      !$past(converter_select_n_i, 4);
  endproperty
  a_sel_rise: assert property (p_sel_rise) // [R9]
    else $error("select opened without a settled low pin");
endmodule // tof_result_regs

// ### tof_host_model.sv
module tof_host_model (
  input wire logic clk_i,
  output logic sel_n_o,
  output logic rd_o,
  output logic [tof_pkg::ADDR_W-1:0] addr_o,
  input wire logic [tof_pkg::DATA_W-1:0] data_i,
  input wire logic valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_n_o = 1'b1;
    rd_o = 1'b0;
    addr_o = '0;
  end
  // Select is a level; reads count only while it is low
  task automatic set_sel(input logic sel_n);
    @(negedge clk_i);
    sel_n_o = sel_n;
  endtask
  // Answer is sampled inside the cycle after the taking edge
  task automatic read(input logic [tof_pkg::ADDR_W-1:0] a,
                      output logic [tof_pkg::DATA_W-1:0] d,
                      output logic v);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    // Released address flips so a stale value cannot pass for a good one
    addr_o = ~a;
    v = valid_i;
    d = data_i;
  endtask
endmodule // tof_host_model

// ### tof_result_regs_tb.sv
module tof_result_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel_n, rd, vld;
  logic [tof_pkg::ADDR_W-1:0] addr;
  logic [tof_pkg::DATA_W-1:0] rdata, d;
  logic v;
  logic res_wr = 1'b0;
  logic avg = 1'b0;
  logic [tof_pkg::IDX_W-1:0] res_idx = 2'h0;
  logic [tof_pkg::FINE_W-1:0] res_fine = 23'h000000;
  logic [tof_pkg::CNT_W-1:0] res_coarse = 16'h0000;
  logic [tof_pkg::EXT_W-1:0] res_ext = 7'h00;
  logic [tof_pkg::DATA_W-1:0] exp_q [6] = '{default: 24'h000000};
  int err_total = 0;
  int samples_checked = 0;

  always #5 clk_i = ~clk_i;

  tof_result_regs #(.PARITY_ODD(1'b0)) u_tof_result_regs (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .converter_select_n_i(sel_n),
    .rd_i(rd), .rd_addr_i(addr), .rd_data_o(rdata), .rd_valid_o(vld),
    .res_wr_i(res_wr), .res_idx_i(res_idx), .res_fine_i(res_fine),
    .res_coarse_i(res_coarse), .res_ext_i(res_ext), .avg_active_i(avg));

  tof_host_model u_tof_host_model (
    .clk_i(clk_i), .sel_n_o(sel_n), .rd_o(rd), .addr_o(addr),
    .data_i(rdata), .valid_i(vld));

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk24(input string what, input logic [23:0] e,
                       input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [23:0] e,
                      input logic ev);
    u_tof_host_model.read(a, d, v);
    chk1("rd_valid_o", ev, v);
    chk24("rd_data_o", e, d);
  endtask

  // Engine write; expectation built from value, extension rule and parity
  task automatic put(input logic [1:0] idx, input logic [22:0] f,
                     input logic [15:0] c, input logic [6:0] x,
                     input logic a);
    logic [6:0] x2;
    x2 = a ? x : 7'h00;
    @(negedge clk_i);
    res_wr = 1'b1;
    res_idx = idx;
    res_fine = f;
    res_coarse = c;
    res_ext = x;
    avg = a;
    @(negedge clk_i);
    res_wr = 1'b0;
    if (idx != 2'd3) begin
      exp_q[2*idx] = {^f, f};
      exp_q[2*idx+1] = {^{x2, c}, x2, c};
    end
  endtask

  task automatic read_all();
    for (int i = 0; i < 6; i++) begin
      rchk(tof_pkg::ADDR_STOP3_FINE + 6'(i), exp_q[i], 1'b1);
    end
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    u_tof_host_model.set_sel(1'b0);
    repeat (6) @(negedge clk_i);
    read_all();
    put(2'd0, 23'h7FFFFF, 16'hFFFF, 7'h55, 1'b1);
    put(2'd1, 23'h000001, 16'h8001, 7'h7F, 1'b1);
    put(2'd2, 23'h2AAAAA, 16'h1234, 7'h01, 1'b0);
    put(2'd3, 23'h123456, 16'hBEEF, 7'h11, 1'b1);
    read_all();
    rchk(6'h13, 24'h000000, 1'b1);
    rchk(6'h1A, 24'h000000, 1'b1);
    rchk(tof_pkg::ADDR_STOP3_FINE, exp_q[0], 1'b1);
    u_tof_host_model.set_sel(1'b1);
    repeat (6) @(negedge clk_i);
    rchk(tof_pkg::ADDR_STOP5_COARSE, exp_q[0], 1'b0);
    put(2'd1, 23'h400000, 16'h0F0F, 7'h40, 1'b1);
    u_tof_host_model.set_sel(1'b0);
    repeat (6) @(negedge clk_i);
    read_all();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    exp_q = '{default: 24'h000000};
    repeat (6) @(negedge clk_i);
    read_all();
    print_verdict();
  end

  // Tests take about a hundred cycles; this span leaves a wide margin
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
endmodule // tof_result_regs_tb
